/* design/watchdog_pkg.sv */
// Purpose: Constants for the watchdog, its shared prescaler and the sleep wake-up sequencer.
// Assumes: Single core clock at 250 MHz; register offsets are byte addresses on an AXI4-Lite slave.
// Notes: The watchdog tick stands in for the dedicated RC oscillator and arrives as an asynchronous pin.
// Summary of operation
// - The watchdog counts on its own oscillator tick and keeps counting while the core sleeps.
// - A timeout during normal execution raises a full watchdog reset.
// - A timeout during sleep wakes the device, which resumes execution instead of resetting.
// - Every timeout, reset or wake-up, clears the timeout status flag.
// - A cleared watchdog fuse disables the watchdog for good, and software cannot turn it back on.
// - With the prescaler assigned to the watchdog, the timeout is the base period times the ratio.
// - The option register holds the assignment bit at bit 3 and the ratio field at bits 2 to 0.
// - The clear and sleep operations reset the watchdog count and the prescaler count when assigned.
// - The clear operation resets the watchdog count and the prescaler count and leaves the assignment bit alone.
// - Crystal modes wait 1024 oscillator periods before resuming from sleep, RC mode waits none.
// - An interrupt wake-up vectors to 0004h if the global enable is set, else continues after sleep.
// - The watchdog fuse enables the watchdog when 1 and disables it when 0.
package watchdog_pkg;
  localparam logic [31:0] OPTION_INDEX      = 32'h0000_0081;
  localparam logic [31:0] CONFIG_INDEX      = 32'h0000_2007;
  localparam logic [31:0] OPTION_OFFSET     = OPTION_INDEX << 2;
  localparam logic [31:0] CONFIG_OFFSET     = CONFIG_INDEX << 2;
  localparam logic [31:0] CONTROL_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET     = 32'h0000_0004;
  localparam logic [7:0]  OPTION_RESET      = 8'hff;
  localparam int          PSA_BIT           = 3;
  localparam int          PS_LSB            = 0;
  localparam int          PS_W              = 3;
  localparam int          FUSE_WDTEN_BIT    = 2;
  localparam int          FUSE_OSC_LSB      = 0;
  localparam logic [1:0]  OSC_RC            = 2'h3;
  localparam int          CTRL_CLEAR_BIT    = 0;
  localparam int          CTRL_SLEEP_BIT    = 1;
  localparam int          CTRL_IRQ_BIT      = 2;
  localparam int          CTRL_GIE_BIT      = 3;
  localparam int          WDT_BASE_BITS     = 8;
  localparam logic [10:0] OST_PERIODS       = 11'h400;
  localparam logic [15:0] IRQ_VECTOR        = 16'h0004;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage : watchdog_pkg

/* design/watchdog_sleep_wakeup.sv */
// Purpose: Watchdog with shared prescaler, timeout flag and sleep wake-up control.
// Assumes: AXI4-Lite register access; fuses are static inputs sampled after reset release.
// Notes: Watchdog tick and oscillator period tick are asynchronous pins, filtered through three flops.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module watchdog_sleep_wakeup (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  fuse_word,
  input  wire logic        wdt_osc_tick,
  input  wire logic        main_osc_input,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             watchdog_reset,
  output logic             sleeping,
  output logic             resume_pulse,
  output logic             resume_vector
);
  typedef enum logic [1:0] {RUN, SLEEP, OST_WAIT} pwr_e;

  logic [7:0]  option_ff;
  logic [7:0]  fuse_ff;
  logic        fuse_taken_ff;
  logic        to_flag_ff;
  logic        timeout_seen_ff;
  logic [2:0]  pin_sync_ff [2];
  logic        pin_lvl_ff [2];
  logic [7:0]  wdt_cnt_ff;
  logic [6:0]  pre_cnt_ff;
  logic [10:0] ost_cnt_ff;
  logic        gie_ff;
  pwr_e        pwr_ff;
  pwr_e        nxt_pwr;
  logic        sleeping_ff;
  logic        aw_ff;
  logic        w_ff;
  logic        aw_rdy_ff;
  logic        w_rdy_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        watchdog_reset_ff;
  logic        resume_pulse_ff;
  logic        resume_vector_ff;

  // Pin 0 is the watchdog oscillator, pin 1 the main oscillator.
  wire [1:0] pin_raw = {main_osc_input, wdt_osc_tick};
  wire [1:0] pin_stable;
  wire [1:0] pin_rise;
  wire tick_rise     = pin_rise[0];
  wire osc_rise      = pin_rise[1];


  wire wdt_enabled   = fuse_taken_ff && fuse_ff[watchdog_pkg::FUSE_WDTEN_BIT];
  wire psa_wdt       = option_ff[watchdog_pkg::PSA_BIT];
  wire [2:0] ps_sel  = option_ff[watchdog_pkg::PS_LSB +: watchdog_pkg::PS_W];
  wire [6:0] pre_max = psa_wdt ? 7'((8'h01 << ps_sel) - 8'h01) : 7'h00;
  wire pre_wrap      = pre_cnt_ff == pre_max;
  wire wdt_timeout   = wdt_enabled && tick_rise && pre_wrap && (&wdt_cnt_ff);

  wire wr_go         = aw_ff && w_ff && !s_axi_bvalid;
  wire wr_ctrl       = wr_go && awaddr_ff == watchdog_pkg::CONTROL_OFFSET;
  wire wr_opt        = wr_go && awaddr_ff == watchdog_pkg::OPTION_OFFSET && wstrb_ff[0];
  wire wr_hit        = awaddr_ff == watchdog_pkg::CONTROL_OFFSET || awaddr_ff == watchdog_pkg::OPTION_OFFSET;
  wire op_clear      = wr_ctrl && wstrb_ff[0] && wdata_ff[watchdog_pkg::CTRL_CLEAR_BIT];
  wire op_sleep      = wr_ctrl && wstrb_ff[0] && wdata_ff[watchdog_pkg::CTRL_SLEEP_BIT] && pwr_ff == RUN;
  wire op_irq        = wr_ctrl && wstrb_ff[0] && wdata_ff[watchdog_pkg::CTRL_IRQ_BIT];
  wire op_gie        = wdata_ff[watchdog_pkg::CTRL_GIE_BIT];
  wire wdt_restart   = op_clear || op_sleep;
  wire crystal_mode  = fuse_ff[watchdog_pkg::FUSE_OSC_LSB +: 2] != watchdog_pkg::OSC_RC;
  wire wake_event    = pwr_ff == SLEEP && (wdt_timeout || op_irq);
  wire ost_done      = osc_rise && ost_cnt_ff == watchdog_pkg::OST_PERIODS - 11'h001;

  // Write channel next values; the ready ports are registered from them.
  wire aw_take       = s_axi_awvalid && s_axi_awready;
  wire w_take        = s_axi_wvalid && s_axi_wready;
  wire nxt_aw        = aw_take || (aw_ff && !wr_go);
  wire nxt_w         = w_take || (w_ff && !wr_go);
  wire nxt_bvalid    = wr_go || (s_axi_bvalid && !s_axi_bready);

  // Read decode runs on the held read address; the handshake edge captures the word.
  wire rd_opt        = s_axi_araddr == watchdog_pkg::OPTION_OFFSET;
  wire rd_cfg        = s_axi_araddr == watchdog_pkg::CONFIG_OFFSET;
  wire rd_sts        = s_axi_araddr == watchdog_pkg::STATUS_OFFSET;
  wire rd_ctl        = s_axi_araddr == watchdog_pkg::CONTROL_OFFSET;
  wire rd_hit        = rd_opt || rd_cfg || rd_sts || rd_ctl;
  wire [31:0] sts_word = {28'h0000000, gie_ff, timeout_seen_ff, sleeping_ff, to_flag_ff};
  wire [31:0] rd_word  =
    rd_opt ? {24'h000000, option_ff} :
    rd_cfg ? {24'h000000, fuse_ff} :
    rd_sts ? sts_word : 32'h0000_0000;

  // Next power state; sleeping is registered from it so the port comes from a flop.
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      RUN: begin
        if (op_sleep) nxt_pwr = SLEEP;
      end
      SLEEP: begin
        if (wake_event) nxt_pwr = crystal_mode ? OST_WAIT : RUN;
      end
      OST_WAIT: begin
        if (ost_done) nxt_pwr = RUN;
      end
      default: begin
        nxt_pwr = RUN;
      end
    endcase
  end

  // Each pin passes three flops; an edge counts once the last two stages agree.
  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign pin_stable[p] = pin_sync_ff[p][1] == pin_sync_ff[p][2];
    assign pin_rise[p]   = pin_stable[p] && pin_sync_ff[p][2] && !pin_lvl_ff[p];

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pin_sync_ff[p] <= 3'h0;
        pin_lvl_ff[p]  <= 1'b0;
      end else begin
        pin_sync_ff[p] <= {pin_sync_ff[p][1:0], pin_raw[p]};
        if (pin_stable[p]) pin_lvl_ff[p] <= pin_sync_ff[p][2];
      end
    end
  end

  // Fuses are captured once after reset and never rewritten.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_ff       <= 8'h00;
      fuse_taken_ff <= 1'b0;
    end else if (!fuse_taken_ff) begin
      fuse_ff       <= fuse_word;
      fuse_taken_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      option_ff <= watchdog_pkg::OPTION_RESET;
    end else if (wr_opt) begin
      option_ff <= wdata_ff[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wdt_cnt_ff <= 8'h00;
      pre_cnt_ff <= 7'h00;
    end else if (wdt_restart || !wdt_enabled) begin
      wdt_cnt_ff <= 8'h00;
      pre_cnt_ff <= 7'h00;
    end else if (tick_rise) begin
      pre_cnt_ff <= pre_wrap ? 7'h00 : pre_cnt_ff + 7'h01;
      if (pre_wrap) wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
    end
  end

  // Flag is active low: set by clear and sleep, cleared by a timeout, which wins.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      to_flag_ff      <= 1'b1;
      timeout_seen_ff <= 1'b0;
    end else if (wdt_timeout) begin
      to_flag_ff      <= 1'b0;
      timeout_seen_ff <= 1'b1;
    end else if (wdt_restart) begin
      to_flag_ff      <= 1'b1;
    end
  end

  // The start-up counter only runs while waiting for the crystal to settle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_ff      <= RUN;
      sleeping_ff <= 1'b0;
      ost_cnt_ff  <= 11'h000;
      gie_ff      <= 1'b0;
    end else begin
      pwr_ff      <= nxt_pwr;
      sleeping_ff <= nxt_pwr != RUN;
      if (op_sleep) gie_ff <= op_gie;
      if (pwr_ff != OST_WAIT) ost_cnt_ff <= 11'h000;
      else if (osc_rise) ost_cnt_ff <= ost_cnt_ff + 11'h001;
    end
  end

  wire resume_now = (pwr_ff == SLEEP && wake_event && !crystal_mode) ||
                    (pwr_ff == OST_WAIT && ost_done);

  logic wake_by_irq_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_by_irq_ff    <= 1'b0;
      watchdog_reset_ff <= 1'b0;
      resume_pulse_ff   <= 1'b0;
      resume_vector_ff  <= 1'b0;
    end else begin
      if (wake_event) wake_by_irq_ff <= op_irq && !wdt_timeout;
      watchdog_reset_ff <= wdt_timeout && pwr_ff == RUN;
      resume_pulse_ff   <= resume_now;
      resume_vector_ff  <= resume_now && gie_ff &&
                           (pwr_ff == SLEEP ? op_irq && !wdt_timeout : wake_by_irq_ff);
    end
  end

  // Address and data are held until both are in; the write lands with bvalid.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      aw_rdy_ff    <= 1'b1;
      w_rdy_ff     <= 1'b1;
      awaddr_ff    <= 32'h0000_0000;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= watchdog_pkg::RESP_OKAY;
    end else begin
      aw_ff        <= nxt_aw;
      w_ff         <= nxt_w;
      aw_rdy_ff    <= !nxt_aw && !nxt_bvalid;
      w_rdy_ff     <= !nxt_w && !nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) s_axi_bresp <= wr_hit ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_awready = aw_rdy_ff;
  assign s_axi_wready  = w_rdy_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= watchdog_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign watchdog_reset = watchdog_reset_ff;
  assign sleeping       = sleeping_ff;
  assign resume_pulse   = resume_pulse_ff;
  assign resume_vector  = resume_vector_ff;
endmodule : watchdog_sleep_wakeup

/* testbench/wdt_sva.sv */
// Purpose: Concurrent checks on the watchdog block's ports.
// Assumes: One clock domain, asynchronous reset active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ns
module wdt_sva (
  input wire logic        core_clk, resetn, watchdog_reset, sleeping, resume_pulse, resume_vector,
  input wire logic [7:0]  fuse_word,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rst_pulse: assert property (watchdog_reset |=> !watchdog_reset) else $error("reset pulse too long");
  a_no_rst_sleep: assert property (sleeping && $past(sleeping) |-> !watchdog_reset)
    else $error("reset raised in sleep");
  a_resume_wake: assert property (resume_pulse |-> !sleeping && $past(sleeping))
    else $error("resume without sleep");
  a_wake_resume: assert property ($fell(sleeping) |-> resume_pulse) else $error("sleep left silently");
  a_vec_pair: assert property (resume_vector |-> resume_pulse) else $error("vector without resume");
  a_fuse_off: assert property (!fuse_word[2] |-> !watchdog_reset) else $error("reset while fused off");
  a_xtal_wait: assert property ($rose(sleeping) && fuse_word[1:0] != 2'h3 |=> sleeping [*8])
    else $error("crystal wake too soon");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : wdt_sva
bind watchdog_sleep_wakeup wdt_sva chk (.*);

/* testbench/osc_model.sv */
// Purpose: Free-running watchdog and main oscillators.
// Assumes: Periods unrelated to the core clock.
// Notes: Both keep running while the core sleeps.
`timescale 1ns/1ns
module osc_model #(parameter int WDT_HALF = 17, parameter int MAIN_HALF = 13) (
  output logic wdt_osc_tick,
  output logic main_osc_input
);
  initial wdt_osc_tick = 1'b0;
  initial main_osc_input = 1'b0;
  always #(WDT_HALF) wdt_osc_tick = ~wdt_osc_tick;
  always #(MAIN_HALF) main_osc_input = ~main_osc_input;
endmodule : osc_model

/* testbench/tb_watchdog_sleep_wakeup.sv */
// Purpose: Self-checking bench for the watchdog block.
// Assumes: Oscillators come from osc_model.
// Notes: Output pulses are counted each clock and compared as counts.
`timescale 1ns/1ns
module tb_watchdog_sleep_wakeup;
  logic        core_clk = 1'b0, resetn = 1'b0, wdt_osc_tick, main_osc_input;
  logic [7:0]  fuse_word = 8'h07;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        watchdog_reset, sleeping, resume_pulse, resume_vector;
  int          n_fail = 0, tests_run = 0, n_rst = 0, n_res = 0, n_vec = 0, ticks = 0, mosc = 0;
  always #2 core_clk = ~core_clk;
  osc_model part (.wdt_osc_tick(wdt_osc_tick), .main_osc_input(main_osc_input));
  watchdog_sleep_wakeup uut (.*);
  always @(posedge wdt_osc_tick) ticks++;
  always @(posedge main_osc_input) mosc++;
  always @(negedge core_clk) begin
    n_rst += watchdog_reset;
    n_res += resume_pulse;
    n_vec += resume_vector;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
    logic aw = 1'b1;
    logic w = 1'b1;
    logic ha = 1'b0;
    logic hw = 1'b0;
    logic hb = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge core_clk);
      ha = aw && s_axi_awready;
      hw = w && s_axi_wready;
      @(posedge core_clk);
      if (ha) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (hw) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!hb) begin
      @(negedge core_clk);
      hb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [31:0] a);
    logic h = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!h) begin
      @(negedge core_clk);
      h = s_axi_arready;
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge core_clk);
      h = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'b0;
  endtask : bus_rd
  task automatic wait_evt(input int lim);
    int s = n_rst + n_res;
    for (int i = 0; i < lim && n_rst + n_res == s; i++) @(posedge core_clk);
  endtask : wait_evt
  task automatic do_reset(input logic [7:0] f);
    resetn <= 1'b0;
    fuse_word <= f;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset
  task automatic t_regs;
    bus_rd(watchdog_pkg::OPTION_OFFSET);
    chk("option reset", 32'hff, rd);
    bus_rd(watchdog_pkg::CONFIG_OFFSET);
    chk("config", 32'h07, rd);
    bus_rd(32'h100);
    chk("unmapped resp", watchdog_pkg::RESP_SLVERR, rr);
    chk("unmapped data", 32'h0, rd);
    bus_rd(watchdog_pkg::STATUS_OFFSET);
    chk("flag at reset", 32'h1, rd[0]);
  endtask : t_regs
  task automatic t_period;
    logic [7:0] opt [4] = '{8'hf8, 8'hf9, 8'hf1, 8'hfa};
    int         n   [4] = '{256, 512, 256, 1024};
    int         s;
    for (int i = 0; i < 4; i++) begin
      bus_wr(watchdog_pkg::OPTION_OFFSET, opt[i]);
      bus_wr(watchdog_pkg::CONTROL_OFFSET, 8'h01);
      ticks = 0;
      s = n_rst;
      wait_evt(10000);
      chk("timeout reset", s + 1, n_rst);
      chk("period", 32'h1, ticks >= n[i] - 3 && ticks <= n[i] + 3);
      bus_rd(watchdog_pkg::OPTION_OFFSET);
      chk("option kept", opt[i], rd);
      bus_rd(watchdog_pkg::STATUS_OFFSET);
      chk("flag cleared", 32'h0, rd[0]);
    end
  endtask : t_period
  task automatic t_clear;
    int s = n_rst;
    bus_wr(watchdog_pkg::OPTION_OFFSET, 8'hf8);
    repeat (3) begin
      bus_wr(watchdog_pkg::CONTROL_OFFSET, 8'h01);
      repeat (1800) @(posedge core_clk);
    end
    chk("clear holds off", s, n_rst);
  endtask : t_clear
  task automatic t_sleep;
    logic [7:0] c [3] = '{8'h0a, 8'h02, 8'h02};
    int         r = n_rst;
    int         v;
    int         s;
    for (int i = 0; i < 3; i++) begin
      v = n_vec;
      s = n_res;
      bus_wr(watchdog_pkg::CONTROL_OFFSET, c[i]);
      ticks = 0;
      chk("sleeping", 32'h1, sleeping);
      if (i < 2) bus_wr(watchdog_pkg::CONTROL_OFFSET, 8'h04);
      wait_evt(i < 2 ? 20 : 10000);
      chk("resume", s + 1, n_res);
      chk("vector", v + (i == 0), n_vec);
    end
    chk("sleep period", 32'h1, ticks >= 253 && ticks <= 259);
    chk("no reset in sleep", r, n_rst);
    bus_rd(watchdog_pkg::STATUS_OFFSET);
    chk("flag after wake", 32'h0, rd[0]);
  endtask : t_sleep
  task automatic t_xtal;
    int s;
    do_reset(8'h04);
    bus_wr(watchdog_pkg::CONTROL_OFFSET, 8'h02);
    s = n_res;
    bus_wr(watchdog_pkg::CONTROL_OFFSET, 8'h04);
    mosc = 0;
    wait_evt(8000);
    chk("crystal resume", s + 1, n_res);
    chk("start-up wait", 32'h1, mosc >= 1021 && mosc <= 1026);
  endtask : t_xtal
  task automatic t_off;
    int s;
    do_reset(8'h03);
    bus_wr(watchdog_pkg::CONFIG_OFFSET, 8'h04);
    chk("config write", watchdog_pkg::RESP_SLVERR, rr);
    s = n_rst;
    repeat (5000) @(posedge core_clk);
    chk("fused off", s, n_rst);
  endtask : t_off
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end
  initial begin
    do_reset(8'h07);
    t_regs();
    t_period();
    t_clear();
    t_sleep();
    t_xtal();
    t_off();
    give_verdict();
  end
endmodule : tb_watchdog_sleep_wakeup
